// [ctbu_core.sv]
// Compare, condition-code test and branch execution unit.
// Assumes the decoder presents one operation per cycle, operands already read,
// extended targets already computed by the address unit.
//
// How it works
// (RULE1) Compares set less, equal or greater code
// (RULE2) Conditional compare skips when code bit two set
// (RULE3) Bit check sets 010 or 000
// (RULE4) Compare then step operand, one cycle
// (RULE5) Test writes one on match, else zero
// (RULE6) Prediction bit on tests is ignored
// (RULE7) Branch prediction hint never alters outcome
// (RULE8) Relative jumps add signed displacement to pointer
// (RULE9) Extended jumps use computed absolute address
// (RULE10) Link jumps save next address first
// (RULE11) Conditional jump on code match, else sequential
// (RULE12) Unordered condition doubles as branch if false
// (RULE13) Fused compare sets code, then branches conditionally
// (RULE14) Bit branches set 010 or 000, then branch
// (RULE15) Each form decoded from its own format
// (RULE16) Code is 100, 010, 001 or 000; an outside cc_load writes any three-bit value
// (RULE17) Condition mask meets code on shared bit
`timescale 1ns/1ps
module ctbu_core
  import ctbu_pkg::*;
#(
  parameter int DISP_W = DISP_W_DEFAULT
)(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Operation from the decoder
  input  wire logic              op_valid,
  input  wire ctbu_op_e          op_kind,
  input  wire ctbu_fmt_e         op_format,
  input  wire logic [2:0]        op_cond,
  input  wire logic              op_predict,
  input  wire logic [4:0]        op_dest,
  // Operands
  input  wire logic [DATA_W-1:0] op_src1,
  input  wire logic [DATA_W-1:0] op_src2,
  input  wire logic [DISP_W-1:0] op_disp,
  input  wire logic [DATA_W-1:0] op_ext_addr,
  // Instruction pointers
  input  wire logic [DATA_W-1:0] instruction_pointer,
  input  wire logic [DATA_W-1:0] next_pointer,
  // Condition code load from arithmetic_controls writes
  input  wire logic              cc_load,
  input  wire logic [2:0]        cc_load_value,
  // Condition code
  output logic      [2:0]        cc,
  // Register write-back
  output logic                   res_valid,
  output logic                   wr_en,
  output logic      [4:0]        wr_idx,
  output logic      [DATA_W-1:0] wr_data,
  // Control flow
  output logic                   jump_en,
  output logic      [DATA_W-1:0] jump_target,
  output logic                   jump_hint,
  output logic                   format_error
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  // Sign extension below needs at least one pad bit; refused at elaboration
  if (DISP_W < 2 || DISP_W > DATA_W - 1) begin : g_disp_check
    $error("ctbu_core: DISP_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand helpers

  logic [DATA_W-1:0] disp_ext;
  logic [DATA_W-1:0] rel_target;
  logic [2:0]        cmp_cc;
  logic              cmp_signed;
  ctbu_width_e       cmp_width;
  logic              sel_bit;
  logic [4:0]        sel_pos;
  logic [DATA_W-1:0] sel_word;
  logic              fmt_bad;

  // Displacement sign extension and relative target
  assign disp_ext   = {{(DATA_W-DISP_W){op_disp[DISP_W-1]}}, op_disp};
  assign rel_target = instruction_pointer + disp_ext; // RULE8

  // Signedness and width of the compare
  always_comb begin
    cmp_signed = 1'b1;
    cmp_width  = CTBU_W_WORD;
    case (op_kind)
      CTBU_CMP_ORD, CTBU_CONCMP_ORD, CTBU_CMPINC_ORD, CTBU_CMPDEC_ORD,
      CTBU_COMPARE_UNSIGNED_AND_JUMP: begin
        cmp_signed = 1'b0;
      end
      CTBU_CMP_INT_BYTE: begin
        cmp_width = CTBU_W_BYTE;
      end
      CTBU_CMP_INT_SHORT: begin
        cmp_width = CTBU_W_SHORT;
      end
      default: begin
        cmp_signed = 1'b1;
      end
    endcase
  end

  // Single comparator shared by every compare form
  ctbu_compare u_compare (
    .lhs       (op_src1),
    .rhs       (op_src2),
    .is_signed (cmp_signed),
    .width     (cmp_width),
    .cc        (cmp_cc)
  );

  // Bit check tests src1 of src2 for branches, src2 of src1 for chkbit
  always_comb begin
    if (op_kind == CTBU_CHECK_BIT) begin
      sel_word = op_src1;
      sel_pos  = op_src2[4:0];
    end else begin
      sel_word = op_src2; // RULE14
      sel_pos  = op_src1[4:0];
    end
  end

  ctbu_bit_select u_bit_select (
    .word     (sel_word),
    .position (sel_pos),
    .bit_one  (sel_bit)
  );

  // Each operation must arrive in its own format
  assign fmt_bad = op_valid && (op_format != ctbu_format_of(op_kind)); // RULE15

  ////////////////////////////////////////////////////////////////////////////
  // Next-state computation

  logic [2:0]        next_cc;
  logic              next_wr_en;
  logic [4:0]        next_wr_idx;
  logic [DATA_W-1:0] next_wr_data;
  logic              next_jump_en;
  logic [DATA_W-1:0] next_jump_target;
  logic              next_jump_hint;
  logic [2:0]        bit_cc;

  assign bit_cc = sel_bit ? CC_EQUAL : CC_NONE; // RULE3 RULE16

  // Whole operation resolves in one pass, so results land together
  always_comb begin
    next_cc          = cc;
    next_wr_en       = 1'b0;
    next_wr_idx      = op_dest;
    next_wr_data     = TEST_FALSE;
    next_jump_en     = 1'b0;
    next_jump_target = next_pointer;
    next_jump_hint   = 1'b0;
    if (op_valid && !fmt_bad) begin
      case (op_kind)
        CTBU_CMP_INT, CTBU_CMP_ORD, CTBU_CMP_INT_BYTE, CTBU_CMP_INT_SHORT: begin
          next_cc = cmp_cc; // RULE1
        end
        CTBU_CONCMP_INT, CTBU_CONCMP_ORD: begin
          if (!cc[CC_SKIP_BIT]) begin
            next_cc = cmp_cc; // RULE2
          end
        end
        CTBU_CHECK_BIT: begin
          next_cc = bit_cc; // RULE3
        end
        CTBU_CMPINC_INT, CTBU_CMPINC_ORD: begin
          next_cc      = cmp_cc; // RULE4
          next_wr_en   = 1'b1;
          next_wr_data = op_src2 + STEP_ONE;
        end
        CTBU_CMPDEC_INT, CTBU_CMPDEC_ORD: begin
          next_cc      = cmp_cc; // RULE4
          next_wr_en   = 1'b1;
          next_wr_data = op_src2 - STEP_ONE;
        end
        CTBU_CONDITION_CODE_TEST: begin
          // Prediction input is not read here at all
          next_wr_en   = 1'b1; // RULE6
          next_wr_data = ctbu_cond_met(op_cond, cc) ? TEST_TRUE : TEST_FALSE; // RULE5
        end
        CTBU_JUMP_REL: begin
          next_jump_en     = 1'b1;
          next_jump_target = rel_target; // RULE8
        end
        CTBU_JUMP_LINK_REL: begin
          next_jump_en     = 1'b1;
          next_jump_target = rel_target; // RULE8
          next_wr_en       = 1'b1;
          next_wr_idx      = LINK_REG_IDX; // RULE10
          next_wr_data     = next_pointer;
        end
        CTBU_EXTENDED_JUMP: begin
          next_jump_en     = 1'b1;
          next_jump_target = op_ext_addr; // RULE9
        end
        CTBU_EXTENDED_JUMP_LINK: begin
          next_jump_en     = 1'b1;
          next_jump_target = op_ext_addr; // RULE9
          next_wr_en       = 1'b1;
          next_wr_idx      = op_dest; // RULE10
          next_wr_data     = next_pointer;
        end
        CTBU_COND_JUMP: begin
          // Empty mask takes on a false result too
          next_jump_en   = ctbu_cond_met(op_cond, cc); // RULE11 RULE12 RULE17
          next_jump_hint = op_predict; // RULE7
          if (next_jump_en) begin
            next_jump_target = rel_target;
          end
        end
        CTBU_COMPARE_SIGNED_AND_JUMP, CTBU_COMPARE_UNSIGNED_AND_JUMP: begin
          next_cc        = cmp_cc; // RULE13
          next_jump_en   = ctbu_cond_met(op_cond, cmp_cc); // RULE13 RULE17
          next_jump_hint = op_predict; // RULE7
          if (next_jump_en) begin
            next_jump_target = rel_target;
          end
        end
        CTBU_JUMP_IF_BIT_SET: begin
          next_cc        = bit_cc; // RULE14
          next_jump_en   = ctbu_cond_met(COND_BIT_SET, bit_cc); // RULE14
          next_jump_hint = op_predict; // RULE7
          if (next_jump_en) begin
            next_jump_target = rel_target;
          end
        end
        CTBU_JUMP_IF_BIT_CLEAR: begin
          next_cc        = bit_cc; // RULE14
          next_jump_en   = ctbu_cond_met(COND_BIT_CLEAR, bit_cc); // RULE12 RULE14
          next_jump_hint = op_predict; // RULE7
          if (next_jump_en) begin
            next_jump_target = rel_target;
          end
        end
        default: begin
          next_cc = cc;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition code register

  // An executing operation wins over an outside load in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cc <= CC_RESET;
    end else if (op_valid && !fmt_bad && next_cc != cc) begin
      cc <= next_cc;
    end else if (cc_load && !(op_valid && !fmt_bad)) begin
      cc <= cc_load_value;
    end else begin
      cc <= next_cc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-back port

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_en   <= 1'b0;
      wr_idx  <= 5'h00;
      wr_data <= TEST_FALSE;
    end else begin
      wr_en   <= next_wr_en;
      wr_idx  <= next_wr_idx;
      wr_data <= next_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control-flow port

  // Hint rides along for fetch; the taken flag never looks at it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      jump_en     <= 1'b0;
      jump_target <= {DATA_W{1'b0}};
      jump_hint   <= 1'b0;
    end else begin
      jump_en     <= next_jump_en;
      jump_target <= next_jump_target;
      jump_hint   <= next_jump_hint; // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion and format status

  // A misformatted operation still completes, with no side effects
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      res_valid    <= 1'b0;
      format_error <= 1'b0;
    end else begin
      res_valid    <= op_valid;
      format_error <= fmt_bad; // RULE15
    end
  end

endmodule

// [ctbu_pkg.sv]
// Shared constants, types and helpers for the compare, test and branch unit.
// Assumes one core clock domain; no other package is needed.
package ctbu_pkg;

  // Data path width
  localparam int DATA_W = 32;

  // Condition code encodings
  localparam logic [2:0] CC_LESS    = 3'h4;
  localparam logic [2:0] CC_EQUAL   = 3'h2;
  localparam logic [2:0] CC_GREATER = 3'h1;
  localparam logic [2:0] CC_NONE    = 3'h0;
  localparam logic [2:0] CC_RESET   = 3'h0;
  localparam int         CC_SKIP_BIT = 2;

  // Results of a condition-code test
  localparam logic [31:0] TEST_TRUE  = 32'h0000_0001;
  localparam logic [31:0] TEST_FALSE = 32'h0000_0000;

  // Step used by compare-and-increment or -decrement
  localparam logic [31:0] STEP_ONE = 32'h0000_0001;

  // Register index of the global link register
  localparam logic [4:0] LINK_REG_IDX = 5'h1E;

  // Condition masks implied by the bit-branch forms
  localparam logic [2:0] COND_BIT_SET   = 3'h2;
  localparam logic [2:0] COND_BIT_CLEAR = 3'h0;

  // Default width of the signed branch displacement
  localparam int DISP_W_DEFAULT = 24;

  // Operation kinds handed over by the decoder
  typedef enum logic [4:0] {
    CTBU_NOP,
    CTBU_CMP_INT,
    CTBU_CMP_ORD,
    CTBU_CMP_INT_BYTE,
    CTBU_CMP_INT_SHORT,
    CTBU_CONCMP_INT,
    CTBU_CONCMP_ORD,
    CTBU_CHECK_BIT,
    CTBU_CMPINC_INT,
    CTBU_CMPINC_ORD,
    CTBU_CMPDEC_INT,
    CTBU_CMPDEC_ORD,
    CTBU_CONDITION_CODE_TEST,
    CTBU_JUMP_REL,
    CTBU_JUMP_LINK_REL,
    CTBU_EXTENDED_JUMP,
    CTBU_EXTENDED_JUMP_LINK,
    CTBU_COND_JUMP,
    CTBU_COMPARE_SIGNED_AND_JUMP,
    CTBU_COMPARE_UNSIGNED_AND_JUMP,
    CTBU_JUMP_IF_BIT_SET,
    CTBU_JUMP_IF_BIT_CLEAR
  } ctbu_op_e;

  // Instruction formats
  typedef enum logic [1:0] {
    CTBU_FMT_REG,
    CTBU_FMT_CTRL,
    CTBU_FMT_COMPARE_BRANCH_FORMAT,
    CTBU_FMT_MEM
  } ctbu_fmt_e;

  // Operand widths for compares
  typedef enum logic [1:0] {
    CTBU_W_WORD,
    CTBU_W_SHORT,
    CTBU_W_BYTE
  } ctbu_width_e;

  // Mask against condition code; empty mask means unordered
  function automatic logic ctbu_cond_met(input logic [2:0] mask, input logic [2:0] cc);
    if (mask == CC_NONE) begin
      return cc == CC_NONE;
    end
    return (mask & cc) != CC_NONE;
  endfunction

  // Format that each operation must arrive in
  function automatic ctbu_fmt_e ctbu_format_of(input ctbu_op_e op);
    case (op)
      CTBU_JUMP_REL, CTBU_JUMP_LINK_REL, CTBU_COND_JUMP: begin
        return CTBU_FMT_CTRL;
      end
      CTBU_EXTENDED_JUMP, CTBU_EXTENDED_JUMP_LINK: begin
        return CTBU_FMT_MEM;
      end
      CTBU_CONDITION_CODE_TEST, CTBU_COMPARE_SIGNED_AND_JUMP,
      CTBU_COMPARE_UNSIGNED_AND_JUMP, CTBU_JUMP_IF_BIT_SET,
      CTBU_JUMP_IF_BIT_CLEAR: begin
        return CTBU_FMT_COMPARE_BRANCH_FORMAT;
      end
      default: begin
        return CTBU_FMT_REG;
      end
    endcase
  endfunction

endpackage

// [ctbu_compare.sv]
// Three-way magnitude compare of two operands into a condition code.
// Assumes operands are already selected; purely combinational.
`timescale 1ns/1ps
module ctbu_compare
  import ctbu_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] lhs,
  input  wire logic [DATA_W-1:0] rhs,
  // Mode
  input  wire logic              is_signed,
  input  wire ctbu_width_e       width,
  // Result
  output logic      [2:0]        cc
);

  logic [DATA_W:0] lhs_x;
  logic [DATA_W:0] rhs_x;

  // Narrow forms compare only their low bits, extended by signedness
  always_comb begin
    case (width)
      CTBU_W_BYTE: begin
        lhs_x = {{(DATA_W-7){is_signed & lhs[7]}}, lhs[7:0]};
        rhs_x = {{(DATA_W-7){is_signed & rhs[7]}}, rhs[7:0]};
      end
      CTBU_W_SHORT: begin
        lhs_x = {{(DATA_W-15){is_signed & lhs[15]}}, lhs[15:0]};
        rhs_x = {{(DATA_W-15){is_signed & rhs[15]}}, rhs[15:0]};
      end
      default: begin
        lhs_x = {is_signed & lhs[DATA_W-1], lhs};
        rhs_x = {is_signed & rhs[DATA_W-1], rhs};
      end
    endcase
  end

  // One extra bit lets a single signed compare serve both kinds
  always_comb begin
    if (lhs_x == rhs_x) begin
      cc = CC_EQUAL;
    end else if ($signed(lhs_x) < $signed(rhs_x)) begin
      cc = CC_LESS;
    end else begin
      cc = CC_GREATER;
    end
  end

endmodule

// [ctbu_bit_select.sv]
// Picks one bit of a word by a five-bit position.
// Assumes only the low five bits of the position matter.
`timescale 1ns/1ps
module ctbu_bit_select
  import ctbu_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] word,
  input  wire logic [4:0]        position,
  // Result
  output logic                   bit_one
);

  // Plain indexed read; upper position bits are dropped by design
  always_comb begin
    bit_one = word[position];
  end

endmodule

// [ctbu_core_props.sv]
// Port-level checks for the compare, test and branch unit.
// Assumes a bind onto ctbu_core; one clock, synchronous reset.
`timescale 1ns/1ps
module ctbu_core_props
  import ctbu_pkg::*;
#(
  parameter int DISP_W = DISP_W_DEFAULT
)(
  // Clock and request
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              op_valid,
  input wire ctbu_op_e          op_kind,
  input wire ctbu_fmt_e         op_format,
  input wire logic [2:0]        op_cond,
  input wire logic              op_predict,
  input wire logic [DATA_W-1:0] op_src1,
  input wire logic [DATA_W-1:0] op_src2,
  input wire logic [DISP_W-1:0] op_disp,
  input wire logic [DATA_W-1:0] op_ext_addr,
  input wire logic [DATA_W-1:0] instruction_pointer,
  input wire logic [DATA_W-1:0] next_pointer,
  // Results
  input wire logic [2:0]        cc,
  input wire logic              res_valid,
  input wire logic              wr_en,
  input wire logic [4:0]        wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              jump_en,
  input wire logic [DATA_W-1:0] jump_target,
  input wire logic              jump_hint,
  input wire logic              format_error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Expected values one cycle on; kept apart from the design's own helpers
  logic              bit_hit;
  logic              test_hit;
  logic [DATA_W-1:0] rel_dest;
  always_ff @(posedge clk_sys) begin
    bit_hit  <= op_src1[op_src2[4:0]];
    test_hit <= (op_cond == 3'h0) ? (cc == 3'h0) : ((op_cond & cc) != 3'h0);
    rel_dest <= instruction_pointer + DATA_W'($signed(op_disp));
  end

  sequence s_fused_less;
    op_valid && op_kind == CTBU_COMPARE_SIGNED_AND_JUMP && op_cond == CC_LESS
      && op_format == CTBU_FMT_COMPARE_BRANCH_FORMAT && $signed(op_src1) < $signed(op_src2);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  chk_result_pulse: assert property (op_valid |=> res_valid)
    else $error("result pulse missing");
  chk_cmp_less: assert property (op_valid && op_kind == CTBU_CMP_INT
    && op_format == CTBU_FMT_REG && $signed(op_src1) < $signed(op_src2) |=> cc == CC_LESS)
    else $error("signed compare not less");
  chk_concmp_skip: assert property (op_valid && cc[2] && op_format == CTBU_FMT_REG
    && op_kind inside {CTBU_CONCMP_INT, CTBU_CONCMP_ORD} |=> $stable(cc))
    else $error("conditional compare changed code");
  chk_bit_code: assert property (op_valid && op_kind == CTBU_CHECK_BIT
    && op_format == CTBU_FMT_REG |=> cc == {1'h0, bit_hit, 1'h0})
    else $error("bit check code wrong");
  chk_test_value: assert property (op_valid && op_kind == CTBU_CONDITION_CODE_TEST
    && op_format == CTBU_FMT_COMPARE_BRANCH_FORMAT |=> wr_en && wr_data == {31'h0, test_hit})
    else $error("test result wrong");
  chk_rel_target: assert property (op_valid && op_kind == CTBU_JUMP_REL
    && op_format == CTBU_FMT_CTRL |=> jump_en && jump_target == rel_dest)
    else $error("relative target wrong");
  chk_link_save: assert property (op_valid && op_kind == CTBU_JUMP_LINK_REL
    && op_format == CTBU_FMT_CTRL |=> wr_en && wr_idx == LINK_REG_IDX
    && wr_data == $past(next_pointer)) else $error("link not saved");
  chk_ext_target: assert property (op_valid && op_kind == CTBU_EXTENDED_JUMP
    && op_format == CTBU_FMT_MEM |=> jump_en && jump_target == $past(op_ext_addr))
    else $error("extended target wrong");
  chk_fused_less: assert property (s_fused_less |=> cc == CC_LESS && jump_en
    && jump_target == rel_dest) else $error("fused compare jump wrong");
  chk_format_refuse: assert property (op_valid && op_kind == CTBU_JUMP_REL
    && op_format == CTBU_FMT_REG |=> format_error && !jump_en && $stable(cc))
    else $error("bad format not refused");
  chk_hint_copy: assert property (op_valid && op_kind == CTBU_COND_JUMP
    && op_format == CTBU_FMT_CTRL |=> jump_hint == $past(op_predict))
    else $error("hint not copied");
endmodule

// [tb_ctbu_core.sv]
// Self-checking bench for ctbu_core: every kind but CTBU_NOP under every mask, then random.
// Assumes a free-running 25 MHz clock; the bench drives all inputs itself.
`timescale 1ns/1ps
module tb_ctbu_core;
  import ctbu_pkg::*;
  localparam int DW = 16;
  logic        clk_sys = 1'h0;
  logic        sys_rst = 1'h1;
  logic        op_valid = 1'h0;
  logic        op_predict = 1'h0;
  logic        cc_load = 1'h0;
  ctbu_op_e    op_kind = CTBU_NOP;
  ctbu_fmt_e   op_format = CTBU_FMT_REG;
  logic [2:0]  op_cond = 3'h0;
  logic [2:0]  cc_load_value = 3'h0;
  logic [4:0]  op_dest = 5'h00;
  logic [31:0] op_src1 = 32'h0, op_src2 = 32'h0, op_ext_addr = 32'h0;
  logic [31:0] instruction_pointer = 32'h0, next_pointer = 32'h0;
  logic [DW-1:0] op_disp = '0;
  logic [2:0]  cc;
  logic [4:0]  wr_idx;
  logic [31:0] wr_data, jump_target;
  logic        res_valid, wr_en, jump_en, jump_hint, format_error;
  int          fails = 0;
  int          n_compared = 0;
  logic [2:0]  mcc = 3'h0;  // Bench copy of the code

  always #20 clk_sys = ~clk_sys;

  ctbu_core #(.DISP_W(DW)) ctbu_core_inst (.clk_sys, .sys_rst, .op_valid, .op_kind,
    .op_format, .op_cond, .op_predict, .op_dest, .op_src1, .op_src2, .op_disp,
    .op_ext_addr, .instruction_pointer, .next_pointer, .cc_load, .cc_load_value, .cc,
    .res_valid, .wr_en, .wr_idx, .wr_data, .jump_en, .jump_target, .jump_hint,
    .format_error);

  ////////////////////////////////////////////////////////////////////////////////
  // Reference helpers
  function automatic ctbu_fmt_e fmt_for(ctbu_op_e k);
    if (k inside {CTBU_JUMP_REL, CTBU_JUMP_LINK_REL, CTBU_COND_JUMP}) return CTBU_FMT_CTRL;
    if (k inside {CTBU_EXTENDED_JUMP, CTBU_EXTENDED_JUMP_LINK}) return CTBU_FMT_MEM;
    if (k >= CTBU_CONDITION_CODE_TEST) return CTBU_FMT_COMPARE_BRANCH_FORMAT;
    return CTBU_FMT_REG;
  endfunction
  function automatic logic [2:0] order3(logic [31:0] a, logic [31:0] b, logic sgn);
    if (a == b) return CC_EQUAL;
    if (sgn ? ($signed(a) < $signed(b)) : (a < b)) return CC_LESS;
    return CC_GREATER;
  endfunction
  function automatic logic hit(logic [2:0] m, logic [2:0] c);
    return (m == 3'h0) ? (c == 3'h0) : ((m & c) != 3'h0);
  endfunction

  task automatic compare(logic [31:0] got, logic [31:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One operation, then one idle cycle; cc_load rides along and must lose
  task automatic do_op(ctbu_op_e k, logic [2:0] cnd, logic [31:0] a, logic [31:0] b,
                       logic bad);
    logic [31:0] ip, np, ext, tgt, dat;
    logic [4:0]  idx;
    logic [2:0]  ncc;
    logic        wr, jmp, isj;
    ip = $urandom;
    np = $urandom;
    ext = $urandom;
    @(posedge clk_sys);
    op_valid <= 1'h1;
    op_kind <= k;
    op_format <= bad ? ctbu_fmt_e'(fmt_for(k) ^ 2'h1) : fmt_for(k);
    op_cond <= cnd;
    op_src1 <= a;
    op_src2 <= b;
    op_disp <= DW'($urandom);
    op_predict <= 1'($urandom);
    op_dest <= 5'($urandom);
    op_ext_addr <= ext;
    instruction_pointer <= ip;
    next_pointer <= np;
    // A refused op lets an outside load through, so keep it quiet then
    cc_load <= bad ? 1'h0 : 1'($urandom);
    cc_load_value <= 3'($urandom);
    #1;
    idx = op_dest;
    ncc = mcc;
    wr = 1'h0;
    jmp = 1'h0;
    dat = np;
    tgt = ip + 32'($signed(op_disp));
    isj = k inside {CTBU_COND_JUMP, CTBU_COMPARE_SIGNED_AND_JUMP,
                    CTBU_COMPARE_UNSIGNED_AND_JUMP, CTBU_JUMP_IF_BIT_SET, CTBU_JUMP_IF_BIT_CLEAR};
    case (k)
      CTBU_CMP_INT, CTBU_CMPINC_INT, CTBU_CMPDEC_INT, CTBU_COMPARE_SIGNED_AND_JUMP:
        ncc = order3(a, b, 1'h1);
      CTBU_CMP_ORD, CTBU_CMPINC_ORD, CTBU_CMPDEC_ORD, CTBU_COMPARE_UNSIGNED_AND_JUMP:
        ncc = order3(a, b, 1'h0);
      CTBU_CMP_INT_BYTE: ncc = order3(32'($signed(a[7:0])), 32'($signed(b[7:0])), 1'h1);
      CTBU_CMP_INT_SHORT: ncc = order3(32'($signed(a[15:0])), 32'($signed(b[15:0])), 1'h1);
      CTBU_CONCMP_INT: ncc = mcc[2] ? mcc : order3(a, b, 1'h1);
      CTBU_CONCMP_ORD: ncc = mcc[2] ? mcc : order3(a, b, 1'h0);
      CTBU_CHECK_BIT: ncc = a[b[4:0]] ? CC_EQUAL : CC_NONE;
      CTBU_JUMP_IF_BIT_SET, CTBU_JUMP_IF_BIT_CLEAR: ncc = b[a[4:0]] ? CC_EQUAL : CC_NONE;
      default: ;
    endcase
    case (k)
      CTBU_CMPINC_INT, CTBU_CMPINC_ORD: {wr, dat} = {1'h1, b + 32'h1};
      CTBU_CMPDEC_INT, CTBU_CMPDEC_ORD: {wr, dat} = {1'h1, b - 32'h1};
      CTBU_CONDITION_CODE_TEST: {wr, dat} = {1'h1, 31'h0, hit(cnd, mcc)};
      CTBU_JUMP_REL: jmp = 1'h1;
      CTBU_JUMP_LINK_REL: {jmp, wr, idx} = {2'h3, LINK_REG_IDX};
      CTBU_EXTENDED_JUMP: {jmp, tgt} = {1'h1, ext};
      CTBU_EXTENDED_JUMP_LINK: {jmp, wr, tgt} = {2'h3, ext};
      CTBU_JUMP_IF_BIT_SET: cnd = CC_EQUAL;
      CTBU_JUMP_IF_BIT_CLEAR: cnd = CC_NONE;
      default: ;
    endcase
    if (isj) begin
      jmp = hit(cnd, ncc);
      tgt = jmp ? tgt : np;
    end
    if (bad) {ncc, wr, jmp, isj} = {mcc, 3'h0};
    @(posedge clk_sys);
    op_valid <= 1'h0;
    cc_load <= 1'h0;
    #1;
    compare(res_valid, 1'h1, "valid");
    compare(format_error, bad, "refusal");
    compare(cc, ncc, "code");
    compare(wr_en, wr, "write");
    if (wr) compare({wr_idx, wr_data}, {idx, dat}, "write back");
    compare(jump_en, jmp, "jump");
    if (jmp || isj) compare(jump_target, tgt, "target");
    if (!bad) compare(jump_hint, isj & op_predict, "hint");
    mcc = ncc;
  endtask

  task automatic load_cc(logic [2:0] v);
    @(posedge clk_sys);
    cc_load <= 1'h1;
    cc_load_value <= v;
    @(posedge clk_sys);
    cc_load <= 1'h0;
    #1;
    compare(cc, v, "load");
    mcc = v;
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: sweep, refusal, random mix and a second reset
  initial begin
    logic [31:0] a;
    void'($urandom(90419));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 compare(cc, CC_RESET, "reset code");
    for (int k = 1; k < 22; k++) begin
      for (int c = 0; c < 8; c++) begin
        a = $urandom;
        load_cc(3'h4 >> ((c + k) % 4));
        do_op(ctbu_op_e'(k), 3'(c), a, c[0] ? a : $urandom, 1'h0);
      end
    end
    do_op(CTBU_JUMP_REL, 3'h0, 32'h0, 32'h0, 1'h1);
    for (int i = 0; i < 400; i++) begin
      a = $urandom;
      do_op(ctbu_op_e'(1 + $urandom % 21), 3'($urandom), a,
            ($urandom % 4 == 0) ? a : $urandom, $urandom % 8 == 0);
    end
    load_cc(CC_LESS);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    @(posedge clk_sys);
    sys_rst <= 1'h0;
    #1 compare(cc, CC_RESET, "second reset");
    tally_and_finish();
  end

  // Guard against a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end
endmodule

bind ctbu_core ctbu_core_props #(.DISP_W(DISP_W)) ctbu_core_props_inst (.clk_sys, .sys_rst,
  .op_valid, .op_kind, .op_format, .op_cond, .op_predict, .op_src1, .op_src2, .op_disp,
  .op_ext_addr, .instruction_pointer, .next_pointer, .cc, .res_valid, .wr_en, .wr_idx,
  .wr_data, .jump_en, .jump_target, .jump_hint, .format_error);
